// >>> hw/i2cee_cfg.svh
/*
 Constants of the two-wire memory front end: sizes, masks, timing
 counts, register offsets and field positions.
 Assumes a 25 MHz system clock on both ends.
*/
`ifndef I2CEE_CFG_SVH
`define I2CEE_CFG_SVH

// ----------------------------------------------------------------
// Memory and bursts
// ----------------------------------------------------------------
`define I2CEE_MEM_DEPTH 256
`define I2CEE_BYTE_BITS 4'h8
`define I2CEE_MULTI_MASK 3'h3
`define I2CEE_PAGE_MASK 3'h7
`define I2CEE_PROG_CYC 16'h0100

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define I2CEE_CLK_PERIOD_NS 40
`define I2CEE_SCL_PERIOD_NS 10000
`define I2CEE_QTR_CYC ((`I2CEE_SCL_PERIOD_NS + 4 * `I2CEE_CLK_PERIOD_NS - 1) / (4 * `I2CEE_CLK_PERIOD_NS))

// ----------------------------------------------------------------
// Controller registers
// ----------------------------------------------------------------
`define I2CEE_REG_CMD 8'h00
`define I2CEE_REG_TXD 8'h04
`define I2CEE_REG_RXD 8'h08
`define I2CEE_REG_STAT 8'h0C
`define I2CEE_CMD_NACK 2
`define I2CEE_STAT_BUSY 0
`define I2CEE_STAT_NACK 1

`endif

// >>> hw/i2cee_pkg.sv
/*
 Types shared by both ends of the two-wire memory link.
 Assumes nothing of its surroundings.
*/
package i2cee_pkg;

   // ----------------------------------------------------------------
   // Memory side states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      S_IDLE = 3'h0,
      S_SEL = 3'h1,
      S_ADDR = 3'h2,
      S_WDATA = 3'h3,
      S_ACK = 3'h4,
      S_RD = 3'h5,
      S_RACK = 3'h6,
      S_PROG = 3'h7
   } i2cee_sst_e;

   // ----------------------------------------------------------------
   // Controller operations
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      OP_START = 2'h0,
      OP_WRITE = 2'h1,
      OP_READ = 2'h2,
      OP_STOP = 2'h3
   } i2cee_op_e;

endpackage

// >>> hw/i2cee_if.sv
/*
 Two-wire link between controller and memory.
 Assumes both lines are pulled up; any enable pulls its line low.
*/
`timescale 1ns/100ps
interface i2cee_if;
   logic scl_oe_m;
   logic sda_oe_m;
   logic sda_oe_s;
   logic scl;
   logic sda;

   // Wired-AND of the open-drain drivers
   assign scl = ~scl_oe_m;
   assign sda = ~(sda_oe_m | sda_oe_s);

   modport master (output scl_oe_m, output sda_oe_m, input scl, input sda);
   modport slave (output sda_oe_s, input scl, input sda);
endinterface

// >>> hw/i2cee_sync.sv
/*
 Two-flop synchroniser with edge pulses for a group of pin inputs.
 Assumes inputs are asynchronous to mclk_in.
*/
`timescale 1ns/100ps
module i2cee_sync #(
   parameter int W = 2
) (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // Pins
   input wire logic [W-1:0] d_in,
   // Synchronised level and edges
   output logic [W-1:0] q_out,
   output logic [W-1:0] rise_out,
   output logic [W-1:0] fall_out
);
   logic [W-1:0] meta_r;
   logic [W-1:0] q_r;
   logic [W-1:0] d_r;
   logic [1:0] age_r;
   logic live;

   // Edges wait until the pipe holds pin samples, not reset zeros,
   // so an idle-high line shows no false rise after reset
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         age_r <= 2'h0;
      end else if (age_r != 2'h3) begin
         age_r <= age_r + 2'h1;
      end
   end
   assign live = (age_r == 2'h3);

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge mclk_in) begin
            if (!rst_n_in) begin
               meta_r[i] <= 1'b0;
               q_r[i] <= 1'b0;
               d_r[i] <= 1'b0;
            end else begin
               meta_r[i] <= d_in[i];
               q_r[i] <= meta_r[i];
               d_r[i] <= q_r[i];
            end
         end
         assign q_out[i] = q_r[i];
         assign rise_out[i] = live & q_r[i] & ~d_r[i];
         assign fall_out[i] = live & ~q_r[i] & d_r[i];
      end
   endgenerate
endmodule // i2cee_sync

// >>> hw/i2cee_slave.sv
/*
 Memory end of the two-wire link: select decode, acknowledge, address
 counter, reads, burst writes and the self-timed programming cycle.
 Assumes the controller owns the serial clock and keeps it slow enough
 for the 25 MHz sampler (several system clocks per clock phase).
*/
`timescale 1ns/100ps
`include "i2cee_cfg.svh"

// Function
// - 256 bytes of eight bits, serially addressed
// - fixed four-bit type code must match
// - three straps give select bits b3 to b1
// - select byte MSB first, b0 is direction
// - master sends start, address, direction, ack slot
// - memory acknowledges each received byte on ninth
// - master acks read bytes, ends with stop
// - current read returns byte at counter
// - random read: write address, restart, read
// - sequential read returns incrementing addresses
// - byte write accepted at either burst level
// - burst select high allows four bytes
// - burst select low allows eight bytes
// - floating burst select reads high, may change
// - protect pin high blocks programming cycles
// - protect variant has no four-byte burst
// - low supply holds reset, ignores commands
// - data line driven open-drain only
// - start and stop seen with clock high
// - stop after write programs, after read idles
// - data sampled on rising clock edge
// - no response during programming cycle
module i2cee_slave #(
   parameter logic [3:0] TYPE_CODE = 4'h6, // Arbitrary type code
   parameter bit HAS_WP = 1'b0,
   parameter logic [15:0] PROG_CYCLES = `I2CEE_PROG_CYC
) (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // Two-wire link
   i2cee_if.slave bus,
   // Straps and mode pins
   input wire logic [2:0] chip_select_straps_in,
   input wire logic burst_sel_in,
   input wire logic write_protect_pin_in,
   input wire logic supply_ok_in,
   // Status
   output logic busy_out
);
   // ----------------------------------------------------------------
   // Pin sampling
   // ----------------------------------------------------------------
   logic [7:0] pin_s;
   logic [7:0] pin_rise;
   logic [7:0] pin_fall;
   logic run;
   logic scl_s;
   logic sda_s;
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   logic wp_on;

   i2cee_sync #(.W(8)) u_sync (
      .mclk_in(mclk_in),
      .rst_n_in(rst_n_in),
      .d_in({supply_ok_in, write_protect_pin_in, burst_sel_in,
             chip_select_straps_in, bus.sda, bus.scl}),
      .q_out(pin_s),
      .rise_out(pin_rise),
      .fall_out(pin_fall)
   );

   assign run = rst_n_in & pin_s[7];
   assign scl_s = pin_s[0];
   assign sda_s = pin_s[1];
   assign scl_rise = pin_rise[0];
   assign scl_fall = pin_fall[0];
   assign start_c = pin_fall[1] & scl_s;
   assign stop_c = pin_rise[1] & scl_s;
   assign wp_on = HAS_WP & pin_s[6];

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [7:0] mem [0:`I2CEE_MEM_DEPTH-1];
   logic [7:0] wbuf [0:7];

   // ----------------------------------------------------------------
   // Protocol state
   // ----------------------------------------------------------------
   i2cee_pkg::i2cee_sst_e st_r;
   i2cee_pkg::i2cee_sst_e after_ack_r;
   logic [3:0] bcnt_r;
   logic [7:0] sh_r;
   logic [7:0] tx_r;
   logic [7:0] cnt_r;
   logic [7:0] base_r;
   logic [3:0] wcount_r;
   logic [2:0] widx_r;
   logic [2:0] mask_r;
   logic oe_r;
   logic [15:0] ptim_r;
   logic byte_done;

   assign byte_done = scl_fall && (bcnt_r == `I2CEE_BYTE_BITS);

   always_ff @(posedge mclk_in) begin
      if (!run) begin
         st_r <= i2cee_pkg::S_IDLE;
         after_ack_r <= i2cee_pkg::S_IDLE;
         bcnt_r <= 4'h0;
         sh_r <= 8'h00;
         tx_r <= 8'h00;
         cnt_r <= 8'h00;
         base_r <= 8'h00;
         wcount_r <= 4'h0;
         widx_r <= 3'h0;
         mask_r <= 3'h0;
         oe_r <= 1'b0;
         ptim_r <= 16'h0000;
      end else if (st_r == i2cee_pkg::S_PROG) begin
         // Bus is ignored until the cycle ends
         oe_r <= 1'b0;
         if (ptim_r == PROG_CYCLES) begin
            st_r <= i2cee_pkg::S_IDLE;
            ptim_r <= 16'h0000;
            wcount_r <= 4'h0;
         end else begin
            ptim_r <= ptim_r + 16'h0001;
         end
      end else if (start_c) begin
         st_r <= i2cee_pkg::S_SEL;
         bcnt_r <= 4'h0;
         oe_r <= 1'b0;
      end else if (stop_c) begin
         bcnt_r <= 4'h0;
         oe_r <= 1'b0;
         // Protected writes end quietly, data is dropped
         if (wcount_r != 4'h0 && !wp_on) begin
            st_r <= i2cee_pkg::S_PROG;
         end else begin
            st_r <= i2cee_pkg::S_IDLE;
            wcount_r <= 4'h0;
         end
      end else begin
         unique case (st_r)
            i2cee_pkg::S_IDLE: begin
            end
            i2cee_pkg::S_SEL, i2cee_pkg::S_ADDR,
            i2cee_pkg::S_WDATA: begin
               if (scl_rise) begin
                  sh_r <= {sh_r[6:0], sda_s};
                  bcnt_r <= bcnt_r + 4'h1;
               end else if (byte_done) begin
                  bcnt_r <= 4'h0;
                  oe_r <= 1'b1;
                  st_r <= i2cee_pkg::S_ACK;
                  if (st_r == i2cee_pkg::S_SEL) begin
                     if (sh_r[7:4] != TYPE_CODE ||
                         sh_r[3:1] != pin_s[4:2]) begin
                        oe_r <= 1'b0;
                        st_r <= i2cee_pkg::S_IDLE;
                     end else if (sh_r[0]) begin
                        after_ack_r <= i2cee_pkg::S_RD;
                     end else begin
                        after_ack_r <= i2cee_pkg::S_ADDR;
                     end
                  end else if (st_r == i2cee_pkg::S_ADDR) begin
                     cnt_r <= sh_r;
                     base_r <= sh_r;
                     wcount_r <= 4'h0;
                     widx_r <= 3'h0;
                     // Burst size is caught per transfer
                     if (HAS_WP || !pin_s[5]) begin
                        mask_r <= `I2CEE_PAGE_MASK;
                     end else begin
                        mask_r <= `I2CEE_MULTI_MASK;
                     end
                     after_ack_r <= i2cee_pkg::S_WDATA;
                  end else begin
                     // Extra bytes wrap inside the burst
                     wbuf[widx_r] <= sh_r;
                     widx_r <= (widx_r + 3'h1) & mask_r;
                     if (wcount_r <= {1'b0, mask_r}) begin
                        wcount_r <= wcount_r + 4'h1;
                     end
                     cnt_r <= cnt_r + 8'h01;
                     after_ack_r <= i2cee_pkg::S_WDATA;
                  end
               end
            end
            i2cee_pkg::S_ACK: begin
               if (scl_fall) begin
                  oe_r <= 1'b0;
                  bcnt_r <= 4'h0;
                  st_r <= after_ack_r;
                  if (after_ack_r == i2cee_pkg::S_RD) begin
                     tx_r <= {mem[cnt_r][6:0], 1'b0};
                     oe_r <= ~mem[cnt_r][7];
                     bcnt_r <= 4'h1;
                  end
               end
            end
            i2cee_pkg::S_RD: begin
               if (byte_done) begin
                  oe_r <= 1'b0;
                  cnt_r <= cnt_r + 8'h01;
                  st_r <= i2cee_pkg::S_RACK;
               end else if (scl_fall) begin
                  oe_r <= ~tx_r[7];
                  tx_r <= {tx_r[6:0], 1'b0};
                  bcnt_r <= bcnt_r + 4'h1;
               end
            end
            i2cee_pkg::S_RACK: begin
               if (scl_rise) begin
                  if (sda_s) begin
                     st_r <= i2cee_pkg::S_IDLE;
                  end else begin
                     // Ack leaves the line to the master until the fall
                     st_r <= i2cee_pkg::S_ACK;
                     after_ack_r <= i2cee_pkg::S_RD;
                  end
               end
            end
            i2cee_pkg::S_PROG: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Programming cycle: one byte per clock from the burst buffer
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_in) begin
      if (run && st_r == i2cee_pkg::S_PROG &&
          ptim_r < {12'h000, wcount_r}) begin
         mem[base_r + ptim_r[7:0]] <= wbuf[ptim_r[2:0]];
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign bus.sda_oe_s = oe_r;
   assign busy_out = (st_r == i2cee_pkg::S_PROG);

endmodule // i2cee_slave

// >>> hw/i2cee_master.sv
/*
 Controller end of the two-wire link: a Wishbone classic slave whose
 commands produce start, byte write, byte read and stop on the link.
 Assumes the bus pull-ups; the memory end never stretches the clock,
 but a held-low clock is waited for anyway.
*/
`timescale 1ns/100ps
`include "i2cee_cfg.svh"

module i2cee_master (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // Wishbone slave
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   // Two-wire link
   i2cee_if.master bus
);
   // ----------------------------------------------------------------
   // Registers and bus slave
   // ----------------------------------------------------------------
   logic ack_r;
   logic [31:0] dat_r;
   logic [7:0] tx_r;
   logic [7:0] rxd_r;
   logic nack_r;
   logic nack_tx_r;
   logic busy_r;
   i2cee_pkg::i2cee_op_e op_r;
   logic req;
   logic wr_ok;
   logic cmd_wr;

   assign req = wb_cyc_in & wb_stb_in & ~ack_r;
   assign wr_ok = req & wb_we_in & wb_sel_in[0] & ~busy_r;
   assign cmd_wr = wr_ok & (wb_adr_in == `I2CEE_REG_CMD);

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         ack_r <= 1'b0;
         dat_r <= 32'h0000_0000;
      end else begin
         ack_r <= req;
         if (req && !wb_we_in) begin
            unique case (wb_adr_in)
               `I2CEE_REG_CMD: dat_r <= {29'h0, nack_tx_r, op_r};
               `I2CEE_REG_TXD: dat_r <= {24'h0, tx_r};
               `I2CEE_REG_RXD: dat_r <= {24'h0, rxd_r};
               `I2CEE_REG_STAT: dat_r <= {30'h0, nack_r, busy_r};
               default: dat_r <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         tx_r <= 8'h00;
      end else if (wr_ok && wb_adr_in == `I2CEE_REG_TXD) begin
         tx_r <= wb_dat_in[7:0];
      end
   end

   assign wb_ack_out = ack_r;
   assign wb_dat_out = dat_r;

   // ----------------------------------------------------------------
   // Quarter-period divider and line sampling
   // ----------------------------------------------------------------
   logic [7:0] qcnt_r;
   logic tick;
   logic [1:0] line_s;
   logic scl_s;
   logic sda_s;

   i2cee_sync #(.W(2)) u_sync (
      .mclk_in(mclk_in),
      .rst_n_in(rst_n_in),
      .d_in({bus.sda, bus.scl}),
      .q_out(line_s),
      .rise_out(),
      .fall_out()
   );
   assign scl_s = line_s[0];
   assign sda_s = line_s[1];
   assign tick = (qcnt_r == 8'(`I2CEE_QTR_CYC - 1));

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in || !busy_r || tick) begin
         qcnt_r <= 8'h00;
      end else begin
         qcnt_r <= qcnt_r + 8'h01;
      end
   end

   // ----------------------------------------------------------------
   // Link sequencer: four quarter phases per bit or condition
   // ----------------------------------------------------------------
   logic [1:0] ph_r;
   logic [3:0] bi_r;
   logic [8:0] rx_r;
   logic scl_oe_r;
   logic sda_oe_r;
   logic out_bit;
   logic stall;

   always_comb begin
      out_bit = 1'b1;
      if (op_r == i2cee_pkg::OP_WRITE && bi_r < `I2CEE_BYTE_BITS) begin
         out_bit = tx_r[3'h7 - bi_r[2:0]];
      end else if (op_r == i2cee_pkg::OP_READ &&
                   bi_r == `I2CEE_BYTE_BITS) begin
         out_bit = nack_tx_r;
      end
   end

   // Level changes that need a high clock wait for it
   assign stall = (ph_r == 2'h2) && !scl_s;

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         busy_r <= 1'b0;
         op_r <= i2cee_pkg::OP_START;
         nack_tx_r <= 1'b0;
         ph_r <= 2'h0;
         bi_r <= 4'h0;
         rx_r <= 9'h000;
         rxd_r <= 8'h00;
         nack_r <= 1'b0;
         scl_oe_r <= 1'b0;
         sda_oe_r <= 1'b0;
      end else if (!busy_r) begin
         if (cmd_wr) begin
            busy_r <= 1'b1;
            op_r <= i2cee_pkg::i2cee_op_e'(wb_dat_in[1:0]);
            nack_tx_r <= wb_dat_in[`I2CEE_CMD_NACK];
            ph_r <= 2'h0;
            bi_r <= 4'h0;
         end
      end else if (tick && !stall) begin
         ph_r <= ph_r + 2'h1;
         unique case (op_r)
            i2cee_pkg::OP_START: begin
               unique case (ph_r)
                  2'h0: sda_oe_r <= 1'b0;
                  2'h1: scl_oe_r <= 1'b0;
                  2'h2: sda_oe_r <= 1'b1;
                  2'h3: begin
                     scl_oe_r <= 1'b1;
                     busy_r <= 1'b0;
                  end
               endcase
            end
            i2cee_pkg::OP_STOP: begin
               unique case (ph_r)
                  2'h0: begin
                     scl_oe_r <= 1'b1;
                     sda_oe_r <= 1'b1;
                  end
                  2'h1: scl_oe_r <= 1'b0;
                  2'h2: sda_oe_r <= 1'b0;
                  2'h3: busy_r <= 1'b0;
               endcase
            end
            i2cee_pkg::OP_WRITE, i2cee_pkg::OP_READ: begin
               unique case (ph_r)
                  2'h0: begin
                     scl_oe_r <= 1'b1;
                     sda_oe_r <= ~out_bit;
                  end
                  2'h1: scl_oe_r <= 1'b0;
                  2'h2: rx_r <= {rx_r[7:0], sda_s};
                  2'h3: begin
                     scl_oe_r <= 1'b1;
                     bi_r <= bi_r + 4'h1;
                     if (bi_r == `I2CEE_BYTE_BITS) begin
                        busy_r <= 1'b0;
                        rxd_r <= rx_r[8:1];
                        nack_r <= rx_r[0];
                     end
                  end
               endcase
            end
         endcase
      end
   end

   assign bus.scl_oe_m = scl_oe_r;
   assign bus.sda_oe_m = sda_oe_r;

endmodule // i2cee_master

// >>> verif/i2cee_chk.sv
/*
 Checker of the two-wire link joining controller and memory end.
 Assumes the wire levels and enables of i2cee_if, one clock domain.
*/
`timescale 1ns/100ps
module i2cee_chk (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // Link signals
   input wire logic scl_oe_m_in,
   input wire logic sda_oe_m_in,
   input wire logic sda_oe_s_in,
   input wire logic scl_in,
   input wire logic sda_in
);
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!rst_n_in);
   logic scl_q_r;
   logic sda_q_r;
   logic idle_r;
   logic [4:0] cnt_r;
   logic start;
   logic stop;
   // ----------------------------------------------------------------
   // Bus conditions, bit count since the last start
   // ----------------------------------------------------------------
   assign start = scl_in & scl_q_r & sda_q_r & ~sda_in;
   assign stop = scl_in & scl_q_r & ~sda_q_r & sda_in;
   always_ff @(posedge mclk_in) begin
      scl_q_r <= scl_in;
      sda_q_r <= sda_in;
   end
   // Saturates so a long read cannot alias into the select byte
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in || start) cnt_r <= 5'h00;
      else if (scl_in & ~scl_q_r & cnt_r != 5'h1F) cnt_r <= cnt_r + 5'h01;
   end
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in || start) idle_r <= 1'b0;
      else if (stop) idle_r <= 1'b1;
   end
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   property p_od;
      sda_oe_s_in && scl_in |-> !sda_oe_m_in;
   endproperty
   a_od: assert property (p_od)
      else $error("both ends pulled data low with clock high");
   property p_hold;
      scl_in && scl_q_r |-> $stable(sda_oe_s_in);
   endproperty
   a_hold: assert property (p_hold)
      else $error("memory changed data with clock high");
   property p_fall;
      $fell(scl_in) |-> $stable(sda_oe_s_in)[*2];
   endproperty
   a_fall: assert property (p_fall)
      else $error("memory changed data too soon after fall");
   property p_sel;
      scl_in && scl_q_r && cnt_r >= 5'h01 && cnt_r <= 5'h08 |-> !sda_oe_s_in;
   endproperty
   a_sel: assert property (p_sel)
      else $error("memory drove line during select byte");
   property p_idle;
      idle_r |-> !sda_oe_s_in;
   endproperty
   a_idle: assert property (p_idle)
      else $error("memory drove line after stop");
   property p_scl_low;
      start |-> ##[1:200] !scl_in;
   endproperty
   a_scl_low: assert property (p_scl_low)
      else $error("clock not low after start");
   property p_bus_idle;
      idle_r |-> !scl_oe_m_in;
   endproperty
   a_bus_idle: assert property (p_bus_idle)
      else $error("clock pulled low while bus idle");
   property p_high_len;
      $rose(scl_in) |-> scl_in[*8];
   endproperty
   a_high_len: assert property (p_high_len)
      else $error("clock high phase too short");
   c_start: cover property (start);
   c_stop: cover property (stop);
   c_ack: cover property (scl_in && cnt_r == 5'h09 && sda_oe_s_in);
   c_rdat: cover property (scl_in && cnt_r > 5'h09 && sda_oe_s_in);
endmodule // i2cee_chk

// >>> verif/i2c_eeprom_slave_frontend_tb.sv
/*
 Testbench joining controller and memory end over one link.
 Assumes the design files and i2cee_cfg.svh on the include path.
*/
`timescale 1ns/100ps
`include "i2cee_cfg.svh"
module i2c_eeprom_slave_frontend_tb;
   localparam logic [3:0] CODE = 4'h6; // Arbitrary type code
   localparam logic [2:0] STRAP = 3'h5;
   logic mclk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic cyc = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0;
   logic [31:0] rdat;
   logic ack;
   logic burst = 1'b1;
   logic sup = 1'b1;
   logic wp = 1'b0;
   logic busy;
   logic [31:0] st;
   logic [7:0] mem [256];
   logic [15:0] rnd = 16'h17C3;
   int miscompares = 0;
   int num_checks = 0;
   i2cee_if i2cee_if_i ();
   i2cee_master i2cee_master_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
      .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr),
      .wb_sel_in(4'hF), .wb_dat_in(dat), .wb_dat_out(rdat),
      .wb_ack_out(ack), .bus(i2cee_if_i.master));
   // Long programming time so a select can land inside it
   i2cee_slave #(.TYPE_CODE(CODE), .PROG_CYCLES(16'h1000)) i2cee_slave_i (
      .mclk_in(mclk_in), .rst_n_in(rst_n_in), .bus(i2cee_if_i.slave),
      .chip_select_straps_in(STRAP), .burst_sel_in(burst),
      .write_protect_pin_in(wp), .supply_ok_in(sup), .busy_out(busy));
   i2cee_chk i2cee_chk_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
      .scl_oe_m_in(i2cee_if_i.scl_oe_m), .sda_oe_m_in(i2cee_if_i.sda_oe_m),
      .sda_oe_s_in(i2cee_if_i.sda_oe_s), .scl_in(i2cee_if_i.scl),
      .sda_in(i2cee_if_i.sda));
   initial begin
      forever #20 mclk_in = ~mclk_in;
   end
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [7:0] sel(input logic [3:0] c,
      input logic [2:0] e, input logic rw);
      return {c, e, rw};
   endfunction
   task automatic give_verdict;
      if (miscompares == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic [7:0] a, input logic w,
      input logic [31:0] d, output logic [31:0] q);
      @(posedge mclk_in);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge mclk_in);
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
   endtask
   task automatic op(input logic n, input i2cee_pkg::i2cee_op_e o,
      input logic [7:0] t);
      logic [31:0] q;
      wb(`I2CEE_REG_TXD, 1'b1, {24'h0, t}, q);
      wb(`I2CEE_REG_CMD, 1'b1, {29'h0, n, o}, q);
      do begin
         wb(`I2CEE_REG_STAT, 1'b0, 32'h0, st);
      end while (st[`I2CEE_STAT_BUSY] !== 1'b0);
   endtask
   task automatic bstart;
      op(1'b0, i2cee_pkg::OP_START, 8'h00);
   endtask
   task automatic bstop;
      op(1'b0, i2cee_pkg::OP_STOP, 8'h00);
   endtask
   task automatic sb(input logic [7:0] b, input logic n);
      op(1'b0, i2cee_pkg::OP_WRITE, b);
      chk({7'h00, st[`I2CEE_STAT_NACK]}, {7'h00, n});
   endtask
   task automatic rd(input logic last, output logic [7:0] b);
      logic [31:0] q;
      op(last, i2cee_pkg::OP_READ, 8'h00);
      wb(`I2CEE_REG_RXD, 1'b0, 32'h0, q);
      b = q[7:0];
   endtask
   task automatic wr(input logic [7:0] a, input int n);
      bstart;
      sb(sel(CODE, STRAP, 1'b0), 1'b0);
      sb(a, 1'b0);
      for (int i = 0; i < n; i++) begin
         rnd = lfsr(rnd);
         mem[8'(a + i)] = rnd[7:0];
         sb(rnd[7:0], 1'b0);
      end
      bstop;
   endtask
   task automatic waitidle;
      while (busy !== 1'b0) @(posedge mclk_in);
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      logic [7:0] a;
      logic [7:0] b;
      repeat (5) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      sup <= 1'b0;
      repeat (4) @(posedge mclk_in);
      bstart;
      sb(sel(CODE, STRAP, 1'b0), 1'b1);
      bstop;
      sup <= 1'b1;
      repeat (8) @(posedge mclk_in);
      bstart;
      sb(sel(CODE ^ 4'h8, STRAP, 1'b0), 1'b1);
      bstart;
      sb(sel(CODE, STRAP ^ 3'h2, 1'b0), 1'b1);
      bstop;
      // Base near the top so the reads wrap past the last byte
      rnd = lfsr(rnd);
      a = 8'hF8 | {5'h00, rnd[2:0]};
      wr(a, 4);
      bstart;
      sb(sel(CODE, STRAP, 1'b0), 1'b1);
      chk({7'h00, busy}, 8'h01);
      bstop;
      waitidle;
      burst <= 1'b0;
      // Without the protect option the pin must not block programming
      wp <= 1'b1;
      wr(a + 8'h04, 8);
      waitidle;
      bstart;
      sb(sel(CODE, STRAP, 1'b0), 1'b0);
      sb(a, 1'b0);
      bstart;
      sb(sel(CODE, STRAP, 1'b1), 1'b0);
      rd(1'b1, b);
      chk(b, mem[a]);
      bstop;
      bstart;
      sb(sel(CODE, STRAP, 1'b1), 1'b0);
      for (int i = 1; i < 12; i++) begin
         rd(i == 11, b);
         chk(b, mem[8'(a + i)]);
      end
      bstop;
      give_verdict;
   end
   initial begin
      repeat (100000) @(posedge mclk_in);
      miscompares++;
      $display("Error at %0t: watchdog expired", $time);
      give_verdict;
   end
endmodule // i2c_eeprom_slave_frontend_tb
